/* rtl/csc_pkg.sv */
// package for the context switch and store command interpreter
// Notes on behaviour
// - head report from the ring writes active ring head at offset from status page base; from a batch it writes nothing and flags cmd_error
// - command type zero in bits 31:29; context switch is opcode 18h
// - pointer equal to current context id means no load, a no-operation
// - on differing pointer save old context, load new, record new pointer
// - bit 2 set restores extended state when switching to new context
// - extended-state enables are kept in the current context id register
// - force-restore bit 1 restores even when pointers match
// - restore-inhibit bit 0 skips loading, keeps hardware context
// - force-restore and restore-inhibit are not stored in context id
// - immediate store writes to system memory are cache snooped
// - header bit 22 picks physical or graphics translated address
// - header bit 21 picks global translation, forced clear in unprivileged batch
// - length 2 means dword write, 3 means qword write
// - dword 3 is low data, dword 4 is upper data for qword
package csc_pkg;
    localparam logic [2:0]  CMD_TYPE_MISC    = 3'h0;
    localparam logic [5:0]  OP_HEAD_REPORT   = 6'h07;
    localparam logic [5:0]  OP_CONTEXT_SW    = 6'h18;
    localparam logic [5:0]  OP_IMM_STORE     = 6'h20;
    localparam logic [5:0]  LEN_DWORD        = 6'h02;
    localparam logic [5:0]  LEN_QWORD        = 6'h03;
    localparam int          TYPE_HI          = 31;
    localparam int          TYPE_LO          = 29;
    localparam int          OP_HI            = 28;
    localparam int          OP_LO            = 23;
    localparam int          ADDR_TYPE_BIT    = 22;
    localparam int          GLOBAL_GTT_BIT   = 21;
    localparam int          LEN_HI           = 5;
    localparam int          LEN_LO           = 0;
    localparam int          CTX_PTR_LO       = 11;
    localparam int          CTX_SPACE_BIT    = 8;
    localparam int          CTX_EXT_HI       = 7;
    localparam int          CTX_EXT_LO       = 4;
    localparam int          CTX_SAVE_EXT_BIT = 3;
    localparam int          CTX_REST_EXT_BIT = 2;
    localparam int          CTX_FORCE_BIT    = 1;
    localparam int          CTX_INHIBIT_BIT  = 0;
    // head report slot offset within status page, dword index
    localparam logic [11:0] HEAD_SLOT_OFS    = 12'h010;

    typedef struct packed {
        logic [20:0] ptr;
        logic        global_space;
        logic [3:0]  ext;
        logic        save_ext;
        logic        restore_ext;
    } csc_ctx_id_s;

    typedef struct packed {
        logic [35:0] addr;
        logic [63:0] data;
        logic        qword;
        logic        translate;
        logic        global_gtt;
        logic        snoop;
    } csc_mem_wr_s;

    typedef struct packed {
        logic        save;
        logic        save_ext;
        logic [20:0] save_ptr;
        logic        load;
        logic        load_ext;
        logic [20:0] load_ptr;
        logic        load_global;
        logic [3:0]  load_hi;
    } csc_ctx_op_s;
endpackage : csc_pkg

/* rtl/csc_cmd_exec.sv */
// command decoder and executor for head report, context switch, immediate store
`timescale 1ns/100ps
module csc_cmd_exec
    import csc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // command dword stream
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [31:0] cmd_dword,
    input  wire logic        cmd_from_batch,
    input  wire logic        cmd_privileged,
    // ring and status page state
    input  wire logic [31:0] ring_head,
    input  wire logic [31:0] status_page_base_reg,
    // memory write path
    output logic             mem_wr_valid,
    input  wire logic        mem_wr_ready,
    output csc_mem_wr_s      mem_wr,
    // context save and restore path
    output logic             ctx_op_valid,
    input  wire logic        ctx_op_done,
    output csc_ctx_op_s      ctx_op,
    // status
    output csc_ctx_id_s      current_context_id_reg,
    output logic             cmd_error,
    output logic             busy
);
    typedef enum logic [2:0] {
        ST_HEADER, ST_DW1, ST_DW2, ST_DW3, ST_DW4, ST_WRITE, ST_CTX, ST_SKIP
    } csc_state_e;

    csc_state_e  state;
    logic [5:0]  opcode;
    logic [5:0]  remain;
    logic        hdr_addr_type;
    logic        hdr_global;
    logic [31:0] dw1;
    logic [31:0] dw2;
    logic [31:0] dw3;

    function automatic logic [5:0] f_opcode(input logic [31:0] d);
        return d[OP_HI:OP_LO];
    endfunction : f_opcode

    // misc class check shared by every opcode match
    function automatic logic f_misc_op(input logic [31:0] d, input logic [5:0] op);
        return d[TYPE_HI:TYPE_LO] == CMD_TYPE_MISC && f_opcode(d) == op;
    endfunction : f_misc_op

    wire         take      = cmd_valid && cmd_ready;
    wire         is_misc   = cmd_dword[TYPE_HI:TYPE_LO] == CMD_TYPE_MISC;
    wire [5:0]   hdr_op    = f_opcode(cmd_dword);
    wire [5:0]   hdr_len   = cmd_dword[LEN_HI:LEN_LO];
    wire         hit_head  = f_misc_op(cmd_dword, OP_HEAD_REPORT);
    wire         op_head   = hit_head && !cmd_from_batch;
    wire         op_ctx    = f_misc_op(cmd_dword, OP_CONTEXT_SW);
    wire         op_store  = f_misc_op(cmd_dword, OP_IMM_STORE);
    wire         bad_head  = hit_head && cmd_from_batch;
    wire         store_q   = remain == LEN_QWORD;
    wire [20:0]  new_ptr   = dw1[31:CTX_PTR_LO];
    wire         same_ptr  = new_ptr == current_context_id_reg.ptr;
    wire         do_load   = (!same_ptr || dw1[CTX_FORCE_BIT]) && !dw1[CTX_INHIBIT_BIT];
    // save whenever the pointer moves, even with the load inhibited
    wire         do_save   = !same_ptr;
    wire         ctx_work  = do_load || do_save;
    // head slot relative to status page base
    wire [31:0]  head_addr = status_page_base_reg + {18'h0, HEAD_SLOT_OFS, 2'h0};
    // global translation is dropped for unprivileged batch streams
    wire         allow_glob = !(cmd_from_batch && !cmd_privileged);
    // store target, low address bits always zero
    wire [35:0]  store_addr = {dw1[3:0], dw2[31:2], 2'h0};

    // requests are built here so the clocked logic only picks one
    csc_mem_wr_s head_wr;
    csc_mem_wr_s store_dw;
    csc_mem_wr_s store_qw;
    csc_ctx_op_s next_op;
    csc_ctx_id_s next_id;

    // head report is a snooped physical dword write
    assign head_wr  = '{addr: {4'h0, head_addr}, data: {32'h0, ring_head},
                        qword: 1'b0, translate: 1'b0, global_gtt: 1'b0,
                        snoop: 1'b1};
    // dword store takes the incoming dword as low data
    assign store_dw = '{addr: store_addr, data: {32'h0, cmd_dword}, qword: 1'b0,
                        translate: hdr_addr_type, global_gtt: hdr_global,
                        snoop: 1'b1};
    // qword store joins held low dword with incoming upper one
    assign store_qw = '{addr: store_addr, data: {cmd_dword, dw3}, qword: 1'b1,
                        translate: hdr_addr_type, global_gtt: hdr_global,
                        snoop: 1'b1};
    // save with the old enables, then load
    assign next_op  = '{save: do_save,
                        save_ext: current_context_id_reg.save_ext,
                        save_ptr: current_context_id_reg.ptr,
                        load: do_load,
                        load_ext: dw1[CTX_REST_EXT_BIT],
                        load_ptr: new_ptr,
                        load_global: dw1[CTX_SPACE_BIT],
                        load_hi: dw1[CTX_EXT_HI:CTX_EXT_LO]};
    // force and inhibit bits are not kept
    assign next_id  = '{ptr: new_ptr,
                        global_space: dw1[CTX_SPACE_BIT],
                        ext: dw1[CTX_EXT_HI:CTX_EXT_LO],
                        save_ext: dw1[CTX_SAVE_EXT_BIT],
                        restore_ext: dw1[CTX_REST_EXT_BIT]};

    // ready drops while a write or context operation is outstanding
    assign cmd_ready = state inside {ST_HEADER, ST_DW1, ST_DW2, ST_DW3, ST_DW4, ST_SKIP};
    assign busy      = state != ST_HEADER;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_HEADER;
            opcode <= 6'h00;
            remain <= 6'h00;
            hdr_addr_type <= 1'b0;
            hdr_global <= 1'b0;
            dw1 <= 32'h0;
            dw2 <= 32'h0;
            dw3 <= 32'h0;
            mem_wr_valid <= 1'b0;
            mem_wr <= '0;
            ctx_op_valid <= 1'b0;
            ctx_op <= '0;
            current_context_id_reg <= '0;
            cmd_error <= 1'b0;
        end else begin
            cmd_error <= 1'b0;
            unique case (state)
                ST_HEADER: if (take) begin
                    opcode <= hdr_op;
                    remain <= hdr_len;
                    hdr_addr_type <= cmd_dword[ADDR_TYPE_BIT];
                    hdr_global <= cmd_dword[GLOBAL_GTT_BIT] && allow_glob;
                    if (op_head) begin
                        mem_wr_valid <= 1'b1;
                        mem_wr <= head_wr;
                        state <= ST_WRITE;
                    end else if (op_ctx || op_store) begin
                        state <= ST_DW1;
                    end else begin
                        cmd_error <= bad_head;
                        // unknown commands are skipped by length only for misc class with nonzero length
                        state <= (is_misc && hdr_len != 6'h00) ? ST_SKIP : ST_HEADER;
                    end
                end

                ST_DW1: if (take) begin
                    dw1 <= cmd_dword;
                    state <= (opcode == OP_CONTEXT_SW) ? ST_CTX : ST_DW2;
                end

                ST_DW2: if (take) begin
                    dw2 <= cmd_dword;
                    state <= ST_DW3;
                end

                // low data is held here in case the store turns out to be a qword
                ST_DW3: if (take) begin
                    dw3 <= cmd_dword;
                    if (store_q) begin
                        state <= ST_DW4;
                    end else begin
                        mem_wr_valid <= 1'b1;
                        mem_wr <= store_dw;
                        state <= ST_WRITE;
                    end
                end

                ST_DW4: if (take) begin
                    mem_wr_valid <= 1'b1;
                    mem_wr <= store_qw;
                    state <= ST_WRITE;
                end

                // request stands unchanged until the far side takes it
                ST_WRITE: if (mem_wr_ready) begin
                    mem_wr_valid <= 1'b0;
                    state <= ST_HEADER;
                end

                // the id register moves only once the switch is reported done
                ST_CTX: begin
                    if (!ctx_op_valid) begin
                        if (ctx_work) begin
                            ctx_op_valid <= 1'b1;
                            ctx_op <= next_op;
                        end else begin
                            state <= ST_HEADER;
                        end
                    end else if (ctx_op_done) begin
                        ctx_op_valid <= 1'b0;
                        // store pointer, address space bit and extended enables only
                        current_context_id_reg <= next_id;
                        state <= ST_HEADER;
                    end
                end

                // unknown misc commands are consumed by length to keep alignment
                ST_SKIP: if (take) begin
                    remain <= remain - 6'h01;
                    if (remain == 6'h01) begin
                        state <= ST_HEADER;
                    end
                end
            endcase
        end
    end
endmodule : csc_cmd_exec

/* test/csc_properties.sv */
// port assertions for the command interpreter
`timescale 1ns/100ps
module csc_properties
    import csc_pkg::*;
(
    // clock, reset and commands
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        cmd_valid,
    input wire logic        cmd_ready,
    input wire logic [31:0] cmd_dword,
    input wire logic        cmd_from_batch,
    // writes, context and status
    input wire logic        mem_wr_valid,
    input wire logic        mem_wr_ready,
    input wire csc_mem_wr_s mem_wr,
    input wire logic        ctx_op_valid,
    input wire logic        ctx_op_done,
    input wire csc_ctx_op_s ctx_op,
    input wire csc_ctx_id_s current_context_id_reg,
    input wire logic        cmd_error,
    input wire logic        busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_snoop; mem_wr_valid |-> mem_wr.snoop; endproperty
    a_snoop: assert property (p_snoop) else $error("store not snooped");
    property p_wr_hold; mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr); endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write dropped early");
    property p_ctx_hold; ctx_op_valid && !ctx_op_done |=> ctx_op_valid && $stable(ctx_op); endproperty
    a_ctx_hold: assert property (p_ctx_hold) else $error("context op dropped");
    property p_refuse; mem_wr_valid || ctx_op_valid |-> !cmd_ready && busy; endproperty
    a_refuse: assert property (p_refuse) else $error("dword accepted while busy");
    property p_id_hold; !(ctx_op_valid && ctx_op_done) |=> $stable(current_context_id_reg); endproperty
    a_id_hold: assert property (p_id_hold) else $error("context id moved");
    property p_err;
        cmd_error |-> $past(cmd_valid && cmd_ready && cmd_from_batch && cmd_dword[28:23] == 6'h07);
    endproperty
    a_err: assert property (p_err) else $error("error without batch head report");
    property p_idle; !busy |-> cmd_ready; endproperty
    a_idle: assert property (p_idle) else $error("idle but not ready");
    property p_excl; ctx_op_valid |-> !mem_wr_valid; endproperty
    a_excl: assert property (p_excl) else $error("write during context op");
    c_qword: cover property (mem_wr_valid && mem_wr_ready && mem_wr.qword);
    c_load: cover property (ctx_op_valid && ctx_op_done && ctx_op.load);
    c_err: cover property (cmd_error);
endmodule : csc_properties

/* test/csc_mem_model.sv */
// memory and context store responder with random latency
`timescale 1ns/100ps
module csc_mem_model (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // requests and answers
    input  wire logic mem_wr_valid,
    output logic      mem_wr_ready,
    input  wire logic ctx_op_valid,
    output logic      ctx_op_done
);
    int wait_wr;
    int wait_ctx;
    // answers move on the falling edge so the design samples them settled
    always @(negedge clk_sys or negedge reset_n) begin
        mem_wr_ready <= 1'b0;
        ctx_op_done  <= 1'b0;
        if (reset_n && mem_wr_valid && !mem_wr_ready) begin
            if (wait_wr == 0) mem_wr_ready <= 1'b1;
            wait_wr <= (wait_wr == 0) ? $urandom_range(3, 0) : wait_wr - 1;
        end
        if (reset_n && ctx_op_valid && !ctx_op_done) begin
            if (wait_ctx == 0) ctx_op_done <= 1'b1;
            wait_ctx <= (wait_ctx == 0) ? $urandom_range(3, 0) : wait_ctx - 1;
        end
    end
endmodule : csc_mem_model

/* test/tb_context_switch_and_store_cmds.sv */
// testbench for the command interpreter
`timescale 1ns/100ps
module tb_context_switch_and_store_cmds;
    import csc_pkg::*;
    typedef struct packed {csc_mem_wr_s m; csc_mem_wr_s v;} csc_exp_s;
    logic        clk_sys = 0, reset_n = 0, cmd_valid = 0, cmd_ready, mem_wr_valid, mem_wr_ready;
    logic        cmd_from_batch = 0, cmd_privileged = 0, ctx_op_valid, ctx_op_done, cmd_error, busy;
    logic [31:0] cmd_dword = '0, ring_head = '0, status_page_base_reg = '0;
    csc_mem_wr_s mem_wr;
    csc_ctx_op_s ctx_op;
    csc_ctx_id_s current_context_id_reg, cur_id = '0;
    csc_exp_s    exp_wr[$], x;
    logic [78:0] exp_ctx[$];
    logic [50:0] pend_ld;
    logic        pend = 0;
    int          n_fail = 0, checked = 0, n_err = 0, err_exp = 0;
    csc_cmd_exec uut (.clk_sys, .reset_n, .cmd_valid, .cmd_ready, .cmd_dword, .cmd_from_batch,
        .cmd_privileged, .ring_head, .status_page_base_reg, .mem_wr_valid, .mem_wr_ready, .mem_wr,
        .ctx_op_valid, .ctx_op_done, .ctx_op, .current_context_id_reg, .cmd_error, .busy);
    csc_mem_model u_mem (.clk_sys, .reset_n, .mem_wr_valid, .mem_wr_ready, .ctx_op_valid,
        .ctx_op_done);
    initial forever #50 clk_sys = ~clk_sys;
    task automatic chk(input logic [127:0] s, input logic [127:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic put(input logic [31:0] d);
        int n = 0;
        cmd_dword = d;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n++ < 500) @(negedge clk_sys);
        @(negedge clk_sys);
    endtask : put
    task automatic idle(input int k);
        cmd_valid = 1'b0;
        repeat (k) @(negedge clk_sys);
    endtask : idle
    task automatic head(input logic b);
        csc_exp_s h = '0;
        h.m.addr = '1;
        h.m.data[31:0] = '1;
        h.v.addr = {4'h0, status_page_base_reg + 32'({HEAD_SLOT_OFS, 2'h0})};
        h.v.data = {32'h0, ring_head};
        cmd_from_batch = b;
        if (!b) exp_wr.push_back(h);
        err_exp += int'(b);
        put({CMD_TYPE_MISC, OP_HEAD_REPORT, 23'h0});
        idle(4);
    endtask : head
    task automatic store(input logic b22, input logic b21, input logic qw);
        logic [29:0] a = 30'($urandom) & ~30'(qw);
        logic [63:0] d = {$urandom, $urandom};
        logic [3:0]  hi = b22 ? 4'h0 : 4'($urandom);
        x.m = '1;
        x.m.data[63:32] = {32{qw}};
        x.v = '{addr:{hi, a, 2'h0}, data:d, qword:qw, translate:b22,
                global_gtt:b21 && !(cmd_from_batch && !cmd_privileged), snoop:1'b1};
        exp_wr.push_back(x);
        put({CMD_TYPE_MISC, OP_IMM_STORE, b22, b21, 15'h0, qw ? LEN_QWORD : LEN_DWORD});
        put({28'h0, hi});
        put({a, 2'h0});
        put(d[31:0]);
        if (qw) put(d[63:32]);
    endtask : store
    // context switch, flags never force and inhibit together
    task automatic ctx(input logic [20:0] p, input logic [8:0] f, input logic op);
        csc_ctx_id_s id = {p, f[8], f[7:4], f[3], f[2]};
        if (op) exp_ctx.push_back({p != cur_id.ptr, cur_id.save_ext, cur_id.ptr, p, !f[0],
                                   f[2] && !f[0], f[8], f[7:4], id});
        if (op) cur_id = id;
        put({CMD_TYPE_MISC, OP_CONTEXT_SW, 23'h0});
        put({p, 2'h0, f});
        put(32'h0);
        idle(2);
        chk(current_context_id_reg, cur_id);
    endtask : ctx
    always @(posedge clk_sys) begin
        if (reset_n && mem_wr_valid && mem_wr_ready) begin
            if (exp_wr.size() == 0) chk(1, 0);
            else begin
                x = exp_wr.pop_front();
                chk(128'(mem_wr & x.m), 128'(x.v & x.m));
            end
        end
        if (reset_n && ctx_op_valid && ctx_op_done) begin
            pend <= 1'b1;
            pend_ld <= {ctx_op.save, ctx_op.save_ext, ctx_op.save_ptr, ctx_op.load_ptr,
                        ctx_op.load, ctx_op.load_ext, ctx_op.load_global, ctx_op.load_hi};
        end
        if (cmd_error === 1'b1) n_err++;
    end
    always @(negedge clk_sys) begin
        if (pend) begin
            pend <= 1'b0;
            if (exp_ctx.size() == 0) chk(1, 0);
            else chk(79'({pend_ld, current_context_id_reg}), exp_ctx.pop_front());
        end
    end
    task automatic results;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end
    initial begin
        void'($urandom(52));
        ring_head = $urandom;
        status_page_base_reg = $urandom & 32'hFFFF_F000;
        repeat (12) @(negedge clk_sys);
        reset_n = 1'b1;
        head(1'b0);
        head(1'b1);
        $display("head report test done");
        for (int i = 0; i < 8; i++) begin
            cmd_from_batch = 1'($urandom);
            cmd_privileged = 1'($urandom);
            store(i[0], i[1], i[2]);
        end
        idle(10);
        $display("immediate store test done");
        ctx(21'h1A5, 9'h05C, 1'b1);
        ctx(21'h1A5, 9'h000, 1'b0);
        ctx(21'h1A5, 9'h102, 1'b1);
        ctx(21'h0C3, 9'h009, 1'b1);
        ctx(21'($urandom) | 21'h100000, {5'($urandom), 2'($urandom), 2'h0}, 1'b1);
        $display("context switch test done");
        chk(n_err, err_exp);
        chk(exp_wr.size() + exp_ctx.size(), 0);
        results();
    end
endmodule : tb_context_switch_and_store_cmds
bind csc_cmd_exec csc_properties u_props (.clk_sys, .reset_n, .cmd_valid, .cmd_ready, .cmd_dword,
    .cmd_from_batch, .mem_wr_valid, .mem_wr_ready, .mem_wr, .ctx_op_valid, .ctx_op_done, .ctx_op,
    .current_context_id_reg, .cmd_error, .busy);
